// ==== rtl/bac_pkg.sv ====
// Package for the burst and auto-restart mode control block.
// Assumes a single 20 MHz system clock and AHB-Lite register access.
package bac_pkg;

  // ==========================================================
  // Clock and timing
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned BLANK_TIME_NS = 8000;
  localparam int unsigned BLANK_CYCLES = (BLANK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATE = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
  localparam logic [7:0] OFS_FLAGS = 8'h10;

  // ==========================================================
  // Field positions and reset values
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_BURST_EN_BIT = 1;
  localparam logic [1:0] CTRL_RESET_VAL = 2'h3;
  localparam logic [5:0] IRQ_MASK_RESET_VAL = 6'h00;

  // Interrupt event bits
  localparam int EV_BURST_ENTER = 0;
  localparam int EV_BURST_EXIT = 1;
  localparam int EV_RESTART_ENTER = 2;
  localparam int EV_OVERVOLT = 3;
  localparam int EV_OVERTEMP = 4;
  localparam int EV_STARTUP = 5;
  localparam int NUM_EVENTS = 6;

  // ==========================================================
  // Types
  typedef enum logic [4:0] {
    ST_STARTUP = 5'h01,
    ST_NORMAL = 5'h02,
    ST_BURST = 5'h04,
    ST_RESTART = 5'h08,
    ST_LOCKOUT = 5'h10
  } bac_state_e;

  typedef struct packed {
    logic light_load_cmp;
    logic burst_high_cmp;
    logic burst_low_cmp;
    logic overload_cmp;
    logic supply_overvolt_cmp;
    logic softstart_phase_cmp;
    logic softstart_upper_cmp;
    logic overtemp_cmp;
    logic supply_under_cmp;
    logic supply_on_cmp;
  } bac_cmp_s;

  localparam int NUM_CMP = 10;

  typedef struct packed {
    logic bias_en;
    logic reduced_limit_sel;
    logic softstart_clamp_release;
    logic switching_en;
    logic startup_cell_on;
    logic reference_en;
  } bac_ctl_s;

endpackage

// ==== rtl/bac_ctrl.sv ====
// Burst mode and auto-restart mode control with AHB-Lite registers.
// Assumes comparator flags arrive asynchronously and soft-start time is set outside.
`timescale 1ns/1ps

module bac_ctrl
  import bac_pkg::*;
#(
  parameter int unsigned BLANK_COUNT = BLANK_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [NUM_CMP-1:0] cmp_in,
  output logic bias_en,
  output logic reduced_limit_sel,
  output logic softstart_clamp_release,
  output logic switching_en,
  output logic startup_cell_on,
  output logic reference_en,
  output logic irq
);

  if (BLANK_COUNT < 1 || BLANK_COUNT > 65535) begin : g_bad_count
    $error("BLANK_COUNT out of range");
  end

  // ==========================================================
  // Synchronisers
  logic [NUM_CMP-1:0] sync1_reg, sync2_reg, sync3_reg;
  logic [NUM_CMP-1:0] stable_reg;
  bac_cmp_s cmp;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
    end else begin
      sync1_reg <= cmp_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CMP; gi++) begin : g_stable
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          stable_reg[gi] <= 1'b0;
        end else if (sync2_reg[gi] == sync3_reg[gi]) begin
          stable_reg[gi] <= sync3_reg[gi];
        end
      end
    end
  endgenerate

  assign cmp = bac_cmp_s'(stable_reg);

  // ==========================================================
  // Registers
  logic [1:0] ctrl_reg;
  logic [NUM_EVENTS-1:0] irq_stat_reg, irq_mask_reg;
  logic burst_flag_reg;
  logic burst_bias_reg;
  bac_state_e state_reg, state_next;

  wire ctl_enable = ctrl_reg[CTRL_ENABLE_BIT];
  wire ctl_burst_en = ctrl_reg[CTRL_BURST_EN_BIT];

  // ==========================================================
  // Spike blanking
  logic [15:0] ov_cnt_reg, ot_cnt_reg;
  logic ov_fault_reg, ot_fault_reg;
  wire ov_qual = cmp.supply_overvolt_cmp & cmp.softstart_phase_cmp & cmp.overload_cmp;
  wire [15:0] blank_last = 16'(BLANK_COUNT - 1);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ov_cnt_reg <= 16'h0000;
      ov_fault_reg <= 1'b0;
    end else if (!ov_qual) begin
      ov_cnt_reg <= 16'h0000;
      ov_fault_reg <= 1'b0;
    end else if (ov_cnt_reg == blank_last) begin
      ov_fault_reg <= 1'b1;
    end else begin
      ov_cnt_reg <= ov_cnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ot_cnt_reg <= 16'h0000;
      ot_fault_reg <= 1'b0;
    end else if (!cmp.overtemp_cmp) begin
      ot_cnt_reg <= 16'h0000;
      ot_fault_reg <= 1'b0;
    end else if (ot_cnt_reg == blank_last) begin
      ot_fault_reg <= 1'b1;
    end else begin
      ot_cnt_reg <= ot_cnt_reg + 16'h0001;
    end
  end

  // ==========================================================
  // Mode state machine
  wire overload_trip = cmp.overload_cmp & cmp.softstart_upper_cmp;
  wire burst_entry = ctl_burst_en & cmp.light_load_cmp & cmp.softstart_upper_cmp;
  wire under_volt = cmp.supply_under_cmp;
  wire fault_any = ov_fault_reg | ot_fault_reg | overload_trip | under_volt;
  wire run_state = (state_reg == ST_NORMAL) | (state_reg == ST_BURST);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_LOCKOUT: begin
        if (cmp.supply_on_cmp && ctl_enable) state_next = ST_STARTUP;
      end
      ST_STARTUP: begin
        if (fault_any) state_next = ST_RESTART;
        else if (!cmp.softstart_phase_cmp) state_next = ST_NORMAL;
      end
      ST_NORMAL: begin
        if (fault_any) state_next = ST_RESTART;
        else if (burst_entry && !cmp.overload_cmp) state_next = ST_BURST;
      end
      ST_BURST: begin
        if (fault_any) state_next = ST_RESTART;
        else if (cmp.overload_cmp) state_next = ST_NORMAL;
      end
      ST_RESTART: begin
        if (cmp.supply_on_cmp && !under_volt && !fault_any) state_next = ST_STARTUP;
        else if (under_volt) state_next = ST_LOCKOUT;
      end
      default: state_next = ST_LOCKOUT;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) state_reg <= ST_LOCKOUT;
    else state_reg <= state_next;
  end

  // Burst flag and bias toggle inside burst
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      burst_flag_reg <= 1'b0;
      burst_bias_reg <= 1'b0;
    end else if (state_next != ST_BURST) begin
      burst_flag_reg <= 1'b0;
      burst_bias_reg <= 1'b0;
    end else if (state_reg != ST_BURST) begin
      burst_flag_reg <= 1'b1;
      burst_bias_reg <= 1'b0;
    end else if (cmp.burst_high_cmp) begin
      burst_bias_reg <= 1'b1;
    end else if (!cmp.burst_low_cmp) begin
      burst_bias_reg <= 1'b0;
    end
  end

  // Startup cell hysteresis: on below the low threshold, off at the high one
  logic cell_hold_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cell_hold_reg <= 1'b1;
    end else if (cmp.supply_under_cmp) begin
      cell_hold_reg <= 1'b1;
    end else if (cmp.supply_on_cmp) begin
      cell_hold_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Control outputs
  bac_ctl_s ctl_next, ctl_reg;
  wire lockout_phase = (state_reg == ST_LOCKOUT) | (state_reg == ST_RESTART);

  always_comb begin
    ctl_next = '0;
    ctl_next.reference_en = ~lockout_phase;
    ctl_next.startup_cell_on = lockout_phase & cell_hold_reg;
    if (state_reg == ST_BURST) begin
      ctl_next.bias_en = burst_bias_reg;
      ctl_next.switching_en = burst_bias_reg;
      ctl_next.reduced_limit_sel = burst_flag_reg & ~cmp.overload_cmp;
      ctl_next.softstart_clamp_release = 1'b1;
    end else if (run_state || state_reg == ST_STARTUP) begin
      ctl_next.bias_en = 1'b1;
      ctl_next.switching_en = (state_reg == ST_NORMAL) | (state_reg == ST_STARTUP);
      ctl_next.softstart_clamp_release = cmp.overload_cmp | cmp.light_load_cmp | (state_reg == ST_STARTUP);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) ctl_reg <= '0;
    else ctl_reg <= ctl_next;
  end

  assign bias_en = ctl_reg.bias_en;
  assign reduced_limit_sel = ctl_reg.reduced_limit_sel;
  assign softstart_clamp_release = ctl_reg.softstart_clamp_release;
  assign switching_en = ctl_reg.switching_en;
  assign startup_cell_on = ctl_reg.startup_cell_on;
  assign reference_en = ctl_reg.reference_en;

  // ==========================================================
  // Events and interrupt
  logic [NUM_EVENTS-1:0] ev;
  logic ov_fault_d_reg, ot_fault_d_reg;
  logic irq_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ov_fault_d_reg <= 1'b0;
      ot_fault_d_reg <= 1'b0;
    end else begin
      ov_fault_d_reg <= ov_fault_reg;
      ot_fault_d_reg <= ot_fault_reg;
    end
  end

  always_comb begin
    ev = '0;
    ev[EV_BURST_ENTER] = (state_next == ST_BURST) & (state_reg != ST_BURST);
    ev[EV_BURST_EXIT] = (state_next != ST_BURST) & (state_reg == ST_BURST);
    ev[EV_RESTART_ENTER] = (state_next == ST_RESTART) & (state_reg != ST_RESTART);
    ev[EV_OVERVOLT] = ov_fault_reg & ~ov_fault_d_reg;
    ev[EV_OVERTEMP] = ot_fault_reg & ~ot_fault_d_reg;
    ev[EV_STARTUP] = (state_next == ST_STARTUP) & (state_reg != ST_STARTUP);
  end

  // ==========================================================
  // AHB-Lite slave
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  wire addr_phase = hsel & hready & htrans[1];
  wire wr_ctrl = wr_pend_reg & (wr_addr_reg == OFS_CTRL);
  wire wr_stat = wr_pend_reg & (wr_addr_reg == OFS_IRQ_STAT);
  wire wr_mask = wr_pend_reg & (wr_addr_reg == OFS_IRQ_MASK);
  wire [NUM_EVENTS-1:0] stat_clr = wr_stat ? hwdata[NUM_EVENTS-1:0] : '0;
  wire [NUM_EVENTS-1:0] stat_next = (irq_stat_reg & ~stat_clr) | ev;

  logic [31:0] rd_mux;
  always_comb begin
    case (haddr)
      OFS_CTRL: rd_mux = {30'h00000000, ctrl_reg};
      OFS_STATE: rd_mux = {24'h000000, 2'h0, burst_flag_reg, state_reg};
      OFS_IRQ_STAT: rd_mux = {26'h0000000, irq_stat_reg};
      OFS_IRQ_MASK: rd_mux = {26'h0000000, irq_mask_reg};
      OFS_FLAGS: rd_mux = {22'h000000, stable_reg};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata <= 32'h00000000;
    end else begin
      wr_pend_reg <= addr_phase & hwrite;
      if (addr_phase) wr_addr_reg <= haddr;
      if (addr_phase && !hwrite) hrdata <= rd_mux;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= CTRL_RESET_VAL;
      irq_mask_reg <= IRQ_MASK_RESET_VAL;
      irq_stat_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      if (wr_ctrl) ctrl_reg <= hwdata[1:0];
      if (wr_mask) irq_mask_reg <= hwdata[NUM_EVENTS-1:0];
      irq_stat_reg <= stat_next;
      irq_reg <= |(stat_next & irq_mask_reg);
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign irq = irq_reg;

endmodule

// ==== dv/bac_ctrl_assertions.sv ====
// Checker for the burst and auto-restart mode control outputs.
// Assumes it is bound to bac_ctrl and sees only its ports.
`timescale 1ns/1ps
module bac_ctrl_assertions
  import bac_pkg::*;
#(
  parameter int unsigned BLANK_COUNT = BLANK_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [NUM_CMP-1:0] cmp_in,
  input wire logic bias_en,
  input wire logic reduced_limit_sel,
  input wire logic switching_en,
  input wire logic startup_cell_on,
  input wire logic reference_en
);
  // ==========
  // Fault persistence counters
  logic [31:0] ot_cnt_reg;
  logic [31:0] ov_cnt_reg;
  wire logic ov_qual = cmp_in[5] & cmp_in[4] & cmp_in[6];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ot_cnt_reg <= 32'h0;
      ov_cnt_reg <= 32'h0;
    end else begin
      ot_cnt_reg <= cmp_in[2] ? ot_cnt_reg + 32'h1 : 32'h0;
      ov_cnt_reg <= ov_qual ? ov_cnt_reg + 32'h1 : 32'h0;
    end
  end
  // ==========
  // Properties
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_OVERLOAD_FULL_LIMIT: assert property (cmp_in[6] [*8] |-> !reduced_limit_sel)
    else $error("reduced limit kept under overload");
  AST_RESTART_ALL_OFF: assert property (!reference_en |-> !bias_en && !switching_en)
    else $error("bias or switching on with reference off");
  AST_CELL_ON_UNDER: assert property (cmp_in[1] [*8] |-> startup_cell_on)
    else $error("startup cell off at low supply");
  AST_CELL_OFF_SUPPLY: assert property ((cmp_in[0] && !cmp_in[1]) [*8] |-> !startup_cell_on)
    else $error("startup cell on at high supply");
  AST_OT_RESTART: assert property (ot_cnt_reg == BLANK_COUNT + 10 |-> !reference_en)
    else $error("overtemperature did not force restart");
  AST_OV_RESTART: assert property (ov_cnt_reg == BLANK_COUNT + 10 |-> !reference_en)
    else $error("qualified overvoltage did not force restart");
  AST_OVERLOAD_RESTART: assert property ((cmp_in[6] && cmp_in[3]) [*8] |-> !reference_en)
    else $error("overload past soft-start did not force restart");
  AST_BURST_BIAS_ON: assert property ((reduced_limit_sel && cmp_in[8]) [*8] |-> bias_en)
    else $error("burst high did not restore bias");
  AST_BURST_BIAS_OFF: assert property ((reduced_limit_sel && !cmp_in[7]) [*8] |-> !bias_en)
    else $error("burst low did not remove bias");
  cover property (reduced_limit_sel && bias_en);
  cover property (!reference_en && !startup_cell_on);
  cover property (startup_cell_on);
  cover property (!reference_en && !startup_cell_on && !cmp_in[0]);
endmodule

bind bac_ctrl bac_ctrl_assertions #(.BLANK_COUNT(BLANK_COUNT)) u_bac_chk (
  .hclk(hclk), .hresetn(hresetn), .cmp_in(cmp_in), .bias_en(bias_en), .reduced_limit_sel(reduced_limit_sel),
  .switching_en(switching_en), .startup_cell_on(startup_cell_on), .reference_en(reference_en)
);

// ==== dv/bac_ctrl_tb.sv ====
// Testbench for the burst and auto-restart mode control block.
// Assumes a shortened blanking count and a zero-wait register bus.
`timescale 1ns/1ps
module bac_ctrl_tb;
  import bac_pkg::*;
  localparam int unsigned BC = 4;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic [NUM_CMP-1:0] cmp_in;
  bac_ctl_s ctl;
  int mismatches, checks;
  // ==========
  // Rows: flags, state register, expected outputs, output care mask
  logic [27:0] rows [17] = '{
    {10'h011,6'h01,6'h00,6'h02}, {10'h001,6'h02,6'h25,6'h3F}, {10'h201,6'h02,6'h2D,6'h3F},
    {10'h209,6'h24,6'h11,6'h37}, {10'h189,6'h24,6'h35,6'h37}, {10'h089,6'h24,6'h35,6'h37},
    {10'h009,6'h24,6'h11,6'h37}, {10'h0C1,6'h02,6'h2D,6'h3F}, {10'h001,6'h02,6'h25,6'h3F},
    {10'h0C9,6'h08,6'h00,6'h3F}, {10'h011,6'h01,6'h00,6'h02}, {10'h001,6'h02,6'h25,6'h37},
    {10'h071,6'h08,6'h00,6'h25}, {10'h001,6'h02,6'h25,6'h25}, {10'h005,6'h08,6'h00,6'h25},
    {10'h002,6'h10,6'h02,6'h03}, {10'h001,6'h02,6'h25,6'h27}
  };
  logic [9:0] spk [2] = '{10'h071, 10'h005};
  bac_ctrl #(.BLANK_COUNT(BC)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .cmp_in(cmp_in), .bias_en(ctl.bias_en), .reduced_limit_sel(ctl.reduced_limit_sel),
    .softstart_clamp_release(ctl.softstart_clamp_release), .switching_en(ctl.switching_en),
    .startup_cell_on(ctl.startup_cell_on), .reference_en(ctl.reference_en), .irq(irq)
  );
  // ==========
  // Tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ==========
  // Clock, watchdog and sequence
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  initial begin
    repeat (3000) @(posedge hclk);
    mismatches++;
    stop_test();
  end
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
    cmp_in = 10'h000;
    repeat (8) @(posedge hclk);
    chk("reset_out", {ctl, irq}, 32'h0);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl", rd, 32'h3);
    bus(1'b0, OFS_IRQ_MASK, 32'h0);
    chk("mask", rd, 32'h0);
    bus(1'b0, OFS_STATE, 32'h0);
    chk("state", rd, 32'h10);
    chk("cell", ctl.startup_cell_on, 32'h1);
    $display("reset test done");
    foreach (rows[i]) begin
      cmp_in <= rows[i][27:18];
      repeat (20) @(posedge hclk);
      bus(1'b0, OFS_STATE, 32'h0);
      chk("state", rd, {26'h0, rows[i][17:12]});
      chk("outputs", ctl & rows[i][5:0], rows[i][11:6]);
      $display("row %0d done", i);
    end
    foreach (spk[j]) begin
      repeat (2) begin
        cmp_in <= spk[j];
        repeat (BC - 1) @(posedge hclk);
        cmp_in <= 10'h001;
        repeat (2) @(posedge hclk);
      end
      repeat (20) @(posedge hclk);
      bus(1'b0, OFS_STATE, 32'h0);
      chk("spike_state", rd, 32'h2);
    end
    $display("spike test done");
    bus(1'b0, OFS_IRQ_STAT, 32'h0);
    chk("irq_stat", rd, 32'h3F);
    chk("irq_masked", irq, 32'h0);
    bus(1'b1, OFS_IRQ_MASK, 32'h4);
    repeat (2) @(posedge hclk);
    chk("irq_on", irq, 32'h1);
    bus(1'b1, OFS_IRQ_STAT, 32'h4);
    repeat (2) @(posedge hclk);
    chk("irq_off", irq, 32'h0);
    bus(1'b0, OFS_IRQ_STAT, 32'h0);
    chk("irq_clr", rd, 32'h3B);
    bus(1'b0, 8'h20, 32'h0);
    chk("unmapped", rd, 32'h0);
    $display("interrupt test done");
    bus(1'b1, OFS_CTRL, 32'h1);
    cmp_in <= 10'h209;
    repeat (20) @(posedge hclk);
    bus(1'b0, OFS_STATE, 32'h0);
    chk("no_burst_state", rd, 32'h2);
    bus(1'b0, OFS_FLAGS, 32'h0);
    chk("flags", rd, 32'h209);
    chk("hresp", hresp, 32'h0);
    cmp_in <= 10'h001;
    repeat (8) @(posedge hclk);
    bus(1'b1, OFS_CTRL, 32'h3);
    bus(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl_back", rd, 32'h3);
    $display("control test done");
    bus(1'b1, OFS_IRQ_STAT, 32'h3F);
    cmp_in <= 10'h005;
    repeat (BC) @(posedge hclk);
    cmp_in <= 10'h001;
    repeat (20) @(posedge hclk);
    bus(1'b0, OFS_IRQ_STAT, 32'h0);
    chk("edge_stat", rd, 32'h34);
    bus(1'b0, OFS_STATE, 32'h0);
    chk("edge_state", rd, 32'h2);
    $display("blanking edge test done");
    cmp_in <= 10'h004;
    repeat (20) @(posedge hclk);
    bus(1'b0, OFS_STATE, 32'h0);
    chk("hold_state", rd, 32'h8);
    chk("hold_cell", ctl.startup_cell_on, 32'h0);
    cmp_in <= 10'h002;
    repeat (10) @(posedge hclk);
    cmp_in <= 10'h000;
    repeat (10) @(posedge hclk);
    bus(1'b0, OFS_STATE, 32'h0);
    chk("charge_state", rd, 32'h10);
    chk("charge_cell", ctl.startup_cell_on, 32'h1);
    $display("supply hold test done");
    hresetn <= 1'b0;
    @(posedge hclk);
    chk("reset_mid", {ctl, irq}, 32'h0);
    hresetn <= 1'b1;
    cmp_in <= 10'h001;
    @(posedge hclk);
    bus(1'b1, OFS_CTRL, 32'h2);
    repeat (10) @(posedge hclk);
    bus(1'b0, OFS_STATE, 32'h0);
    chk("disabled_state", rd, 32'h10);
    chk("disabled_cell", ctl.startup_cell_on, 32'h0);
    bus(1'b0, OFS_IRQ_STAT, 32'h0);
    chk("reset_stat", rd, 32'h0);
    bus(1'b1, OFS_CTRL, 32'h3);
    repeat (20) @(posedge hclk);
    bus(1'b0, OFS_STATE, 32'h0);
    chk("enabled_state", rd, 32'h2);
    $display("mid reset test done");
    stop_test();
  end
endmodule
